// *** inc/pmsvr_pkg.sv ***
// pmsvr_pkg: register offsets, field layout and reset codes of the shutdown and voltage slice
package pmsvr_pkg;

  // register offsets on the 8-bit register address space
  localparam logic [7:0] PMSVR_OFS_SHUTDOWN = 8'h91; // emergency_shutdown_control
  localparam logic [7:0] PMSVR_OFS_CONV4 = 8'h94; // converter4_voltage_code
  localparam logic [7:0] PMSVR_OFS_CONV5 = 8'h96; // converter5_voltage_code
  localparam logic [7:0] PMSVR_OFS_CONV6 = 8'h98; // converter6_voltage_code
  localparam logic [7:0] PMSVR_OFS_LDO2 = 8'h9a; // ldo2_normal_sleep_voltage

  // field positions
  localparam int PMSVR_SHUTDOWN_BIT = 0; // force_shutdown_bit
  localparam int PMSVR_VID_MSB = 6; // top bit of a converter voltage field
  localparam int PMSVR_LDO_SLP_MSB = 7; // sleep field of the ldo register
  localparam int PMSVR_LDO_SLP_LSB = 4;
  localparam int PMSVR_LDO_NRM_MSB = 3; // normal field of the ldo register
  localparam int PMSVR_LDO_NRM_LSB = 0;

  // reset values
  localparam logic [7:0] PMSVR_RST_SHUTDOWN = 8'h00;
  localparam logic [6:0] PMSVR_RST_CONV4 = 7'h2f;
  localparam logic [6:0] PMSVR_RST_CONV5 = 7'h4b;
  localparam logic [6:0] PMSVR_RST_CONV6_V0 = 7'h3d; // factory variant 0
  localparam logic [6:0] PMSVR_RST_CONV6_V1 = 7'h47; // factory variant 1
  localparam logic [6:0] PMSVR_RST_CONV6_V2 = 7'h56; // factory variant 2
  localparam logic [7:0] PMSVR_RST_LDO2_STD = 8'haa; // standard variants, both fields 1010
  localparam logic [7:0] PMSVR_RST_LDO2_LOW = 8'h00; // low-voltage variant, both fields 0000

  // the zero-volt converter code, which is a valid setting
  localparam logic [6:0] PMSVR_VID_ZERO = 7'h00;

  // factory variant selector codes
  localparam logic [1:0] PMSVR_VAR_A = 2'h0; // conv6 variant 0, standard ldo2
  localparam logic [1:0] PMSVR_VAR_B = 2'h1; // conv6 variant 1, standard ldo2
  localparam logic [1:0] PMSVR_VAR_C = 2'h2; // conv6 variant 2, standard ldo2
  localparam logic [1:0] PMSVR_VAR_D = 2'h3; // conv6 variant 0, low-voltage ldo2

  // synchroniser depth for pin inputs
  localparam int PMSVR_SYNC_STAGES = 2;

  // reset code of converter six for a variant
  function automatic logic [6:0] pmsvr_conv6_reset(input logic [1:0] variant);
    case (variant)
      PMSVR_VAR_B: pmsvr_conv6_reset = PMSVR_RST_CONV6_V1;
      PMSVR_VAR_C: pmsvr_conv6_reset = PMSVR_RST_CONV6_V2;
      default: pmsvr_conv6_reset = PMSVR_RST_CONV6_V0;
    endcase
  endfunction

  // reset value of the ldo two register for a variant
  function automatic logic [7:0] pmsvr_ldo2_reset(input logic [1:0] variant);
    if (variant == PMSVR_VAR_D)
    begin
      pmsvr_ldo2_reset = PMSVR_RST_LDO2_LOW;
    end
    else
    begin
      pmsvr_ldo2_reset = PMSVR_RST_LDO2_STD;
    end
  endfunction

endpackage

// *** logic/pmsvr_regs.sv ***
// pmsvr_regs: shutdown control, converter voltage codes and ldo two voltage register slice
// Functional notes
// [RQ1] writing one to shutdown bit forces shutdown
// [RQ2] shutdown bit self-clears; writing zero does nothing
// [RQ3] shutdown register resets zero; only bit 0 writable
// [RQ4] converter four code at 94h, reset 2fh
// [RQ5] zero code valid; power-good held asserted
// [RQ6] converter five code at 96h, reset 4bh
// [RQ7] converter six code at 98h, variant reset
// [RQ8] ldo two register at 9Ah, variant reset
// [RQ9] sleep request low selects ldo sleep code
// [RQ10] host sets sleep code equal when unwanted
// [RQ11] upper nibble sleep code, lower nibble normal
// [RQ12] reserved bits read zero, writes ignored
`timescale 1ns/100ps
module pmsvr_regs #(
  parameter logic [1:0] FACTORY_VARIANT = pmsvr_pkg::PMSVR_VAR_A // fuse-chosen reset set
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  input wire logic sleep_request_n,
  output logic force_shutdown,
  output logic [6:0] converter_four_code,
  output logic [6:0] converter_five_code,
  output logic [6:0] converter_six_code,
  output logic [3:0] ldo_two_code,
  output logic ldo_two_in_sleep,
  output logic [2:0] power_good_hold
);

  // reset codes that depend on the factory variant, fixed at build time
  // a field-programmed part would need these as loaded registers instead
  localparam logic [6:0] CONV6_RESET = pmsvr_pkg::pmsvr_conv6_reset(FACTORY_VARIANT);
  localparam logic [7:0] LDO2_RESET = pmsvr_pkg::pmsvr_ldo2_reset(FACTORY_VARIANT);

  // stored register state; the variant resets cost nothing at run time
  // because the variant is a build-time parameter, not a fuse read at power-up
  logic force_shutdown_bit; // lives for one cycle only
  logic [6:0] converter4_voltage_field; // converter four normal code
  logic [6:0] converter5_voltage_field; // converter five normal code
  logic [6:0] converter6_voltage_field; // converter six normal code
  logic [3:0] ldo2_sleep_voltage_field; // ldo two sleep code
  logic [3:0] ldo2_normal_voltage_field; // ldo two normal code

  // next values of register state
  logic next_force_shutdown_bit;
  logic [6:0] next_conv4;
  logic [6:0] next_conv5;
  logic [6:0] next_conv6;
  logic [3:0] next_ldo2_sleep;
  logic [3:0] next_ldo2_normal;

  // next values of the read port
  logic [7:0] next_reg_rdata;
  logic next_reg_rd_valid;

  // next values of the regulator-facing outputs
  // every output below leaves straight from a flop
  logic next_force_shutdown;
  logic [6:0] next_converter_four_code;
  logic [6:0] next_converter_five_code;
  logic [6:0] next_converter_six_code;
  logic [3:0] next_ldo_two_code;
  logic next_ldo_two_in_sleep;
  logic [2:0] next_power_good_hold;

  // sleep request after the two-flop crossing
  // it resets high, so the ldo starts on its normal code
  logic sleep_req_sync_n;

  // the sleep pin arrives from outside the clock domain
  // two flops cost two cycles of sleep latency, far below any regulator settling
  pmsvr_sync u_sleep_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in(sleep_request_n),
    .sync_out(sleep_req_sync_n)
  );

  // write-side decode helper, shared by every register
  function automatic logic wr_hit(input logic en, input logic [7:0] addr, input logic [7:0] ofs);
    wr_hit = en && (addr == ofs);
  endfunction

  // zero-volt test of a converter code, shared by the three power-good holds
  function automatic logic is_zero_code(input logic [6:0] code);
    is_zero_code = (code == pmsvr_pkg::PMSVR_VID_ZERO);
  endfunction

  // shutdown bit next state
  always_comb
  begin
    // the bit never holds: it is one only in the cycle after a write of one
    next_force_shutdown_bit = 1'b0; // RQ2
    if (wr_hit(reg_wr_en, reg_addr, pmsvr_pkg::PMSVR_OFS_SHUTDOWN))
    begin
      // only bit 0 is taken; bits 7..1 are read-only and dropped
      next_force_shutdown_bit = reg_wdata[pmsvr_pkg::PMSVR_SHUTDOWN_BIT]; // RQ1 RQ3
    end
  end

  // shutdown bit storage; a reset in mid-pulse drops the request, the safe side
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      force_shutdown_bit <= pmsvr_pkg::PMSVR_RST_SHUTDOWN[pmsvr_pkg::PMSVR_SHUTDOWN_BIT]; // RQ3
    end
    else
    begin
      force_shutdown_bit <= next_force_shutdown_bit;
    end
  end

  // converter codes next state
  always_comb
  begin
    // codes hold unless written; bit 7 is reserved and discarded
    next_conv4 = converter4_voltage_field;
    next_conv5 = converter5_voltage_field;
    next_conv6 = converter6_voltage_field;
    if (wr_hit(reg_wr_en, reg_addr, pmsvr_pkg::PMSVR_OFS_CONV4))
    begin
      // zero is stored like any other code
      next_conv4 = reg_wdata[pmsvr_pkg::PMSVR_VID_MSB:0]; // RQ4 RQ12
    end
    if (wr_hit(reg_wr_en, reg_addr, pmsvr_pkg::PMSVR_OFS_CONV5))
    begin
      // no range check: every 7-bit code is a legal setting
      next_conv5 = reg_wdata[pmsvr_pkg::PMSVR_VID_MSB:0]; // RQ6 RQ12
    end
    if (wr_hit(reg_wr_en, reg_addr, pmsvr_pkg::PMSVR_OFS_CONV6))
    begin
      // a write replaces the variant reset code until the next reset
      next_conv6 = reg_wdata[pmsvr_pkg::PMSVR_VID_MSB:0]; // RQ7 RQ12
    end
  end

  // converter code storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      converter4_voltage_field <= pmsvr_pkg::PMSVR_RST_CONV4; // RQ4
      converter5_voltage_field <= pmsvr_pkg::PMSVR_RST_CONV5; // RQ6
      converter6_voltage_field <= CONV6_RESET; // RQ7
    end
    else
    begin
      converter4_voltage_field <= next_conv4;
      converter5_voltage_field <= next_conv5;
      converter6_voltage_field <= next_conv6;
    end
  end

  // ldo two next state
  always_comb
  begin
    // both nibbles are taken in one write; there are no reserved bits here
    next_ldo2_sleep = ldo2_sleep_voltage_field;
    next_ldo2_normal = ldo2_normal_voltage_field;
    if (wr_hit(reg_wr_en, reg_addr, pmsvr_pkg::PMSVR_OFS_LDO2))
    begin
      // equal nibbles are the host's way to turn the sleep change off
      next_ldo2_sleep = reg_wdata[pmsvr_pkg::PMSVR_LDO_SLP_MSB:pmsvr_pkg::PMSVR_LDO_SLP_LSB]; // RQ8 RQ11
      next_ldo2_normal = reg_wdata[pmsvr_pkg::PMSVR_LDO_NRM_MSB:pmsvr_pkg::PMSVR_LDO_NRM_LSB]; // RQ8 RQ11
    end
  end

  // ldo two storage
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ldo2_sleep_voltage_field <= LDO2_RESET[pmsvr_pkg::PMSVR_LDO_SLP_MSB:pmsvr_pkg::PMSVR_LDO_SLP_LSB]; // RQ8
      ldo2_normal_voltage_field <= LDO2_RESET[pmsvr_pkg::PMSVR_LDO_NRM_MSB:pmsvr_pkg::PMSVR_LDO_NRM_LSB]; // RQ8
    end
    else
    begin
      ldo2_sleep_voltage_field <= next_ldo2_sleep;
      ldo2_normal_voltage_field <= next_ldo2_normal;
    end
  end

  // read port next state: data is registered, so it appears one cycle after the strobe
  always_comb
  begin
    // a read in the same cycle as a write returns the old contents
    next_reg_rd_valid = reg_rd_en;
    next_reg_rdata = 8'h00; // unmapped addresses read as zero
    if (reg_rd_en)
    begin
      case (reg_addr)
        pmsvr_pkg::PMSVR_OFS_SHUTDOWN:
        begin
          // reserved upper bits read zero; the bit shows its one-cycle life only
          next_reg_rdata = {7'h00, force_shutdown_bit}; // RQ3 RQ12
        end
        pmsvr_pkg::PMSVR_OFS_CONV4:
        begin
          // reserved bit 7 reads zero whatever was written to it
          next_reg_rdata = {1'b0, converter4_voltage_field}; // RQ4 RQ12
        end
        pmsvr_pkg::PMSVR_OFS_CONV5:
        begin
          // same layout as converter four
          next_reg_rdata = {1'b0, converter5_voltage_field}; // RQ6 RQ12
        end
        pmsvr_pkg::PMSVR_OFS_CONV6:
        begin
          // shows the variant reset code until the host writes
          next_reg_rdata = {1'b0, converter6_voltage_field}; // RQ7 RQ12
        end
        pmsvr_pkg::PMSVR_OFS_LDO2:
        begin
          // sleep nibble on top, normal nibble below
          next_reg_rdata = {ldo2_sleep_voltage_field, ldo2_normal_voltage_field}; // RQ11
        end
        default:
        begin
          // unmapped offsets answer with zero rather than stall the host
          next_reg_rdata = 8'h00;
        end
      endcase
    end
  end

  // read port registers
  // an idle port shows zero, so a late sample never sees stale data
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rd_valid <= 1'b0;
    end
    else
    begin
      reg_rdata <= next_reg_rdata;
      reg_rd_valid <= next_reg_rd_valid;
    end
  end

  // regulator-facing next state
  always_comb
  begin
    // shutdown request is a one-cycle pulse that follows the stored bit
    // one cycle of lag here keeps the output straight from a flop
    next_force_shutdown = force_shutdown_bit; // RQ1
    // codes go to the regulators unchanged, zero included
    next_converter_four_code = converter4_voltage_field;
    next_converter_five_code = converter5_voltage_field;
    next_converter_six_code = converter6_voltage_field;
    // a zero-volt code must not drop power-good: tell the monitor to hold it
    next_power_good_hold[0] = is_zero_code(converter4_voltage_field); // RQ5
    next_power_good_hold[1] = is_zero_code(converter5_voltage_field); // RQ5
    next_power_good_hold[2] = is_zero_code(converter6_voltage_field); // RQ5
    // sleep is requested by a low level; with equal codes the switch is invisible
    // only the synced level is used here, never the raw pin
    next_ldo_two_in_sleep = !sleep_req_sync_n; // RQ9
    if (!sleep_req_sync_n)
    begin
      // sleep: a straight switch, any ramping belongs to the regulator
      next_ldo_two_code = ldo2_sleep_voltage_field; // RQ9
    end
    else
    begin
      // awake: the normal code
      next_ldo_two_code = ldo2_normal_voltage_field; // RQ9
    end
  end

  // regulator-facing output registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      force_shutdown <= 1'b0;
      // same codes as the register file resets to, so no false step leaves here
      converter_four_code <= pmsvr_pkg::PMSVR_RST_CONV4;
      converter_five_code <= pmsvr_pkg::PMSVR_RST_CONV5;
      converter_six_code <= CONV6_RESET;
      // the synchroniser resets to awake, so the normal code is shown first
      ldo_two_code <= LDO2_RESET[pmsvr_pkg::PMSVR_LDO_NRM_MSB:pmsvr_pkg::PMSVR_LDO_NRM_LSB];
      ldo_two_in_sleep <= 1'b0;
      // none of the converter reset codes is zero, so no hold is asked at reset
      power_good_hold <= 3'h0;
    end
    else
    begin
      force_shutdown <= next_force_shutdown;
      converter_four_code <= next_converter_four_code;
      converter_five_code <= next_converter_five_code;
      converter_six_code <= next_converter_six_code;
      ldo_two_code <= next_ldo_two_code;
      ldo_two_in_sleep <= next_ldo_two_in_sleep;
      power_good_hold <= next_power_good_hold;
    end
  end

endmodule

// *** logic/pmsvr_sync.sv ***
// pmsvr_sync: two-flop synchroniser for a single asynchronous pin level
`timescale 1ns/100ps
module pmsvr_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic async_in,
  output logic sync_out
);

  // stage one is read only by stage two, never by any other logic
  logic stage1;
  logic next_stage1;
  logic next_sync_out;

  // next values: plain shift toward the output
  always_comb
  begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // reset to high, the idle level of an active-low request
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      stage1 <= 1'b1;
      sync_out <= 1'b1;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end

endmodule

// *** testbench/pmsvr_host.sv ***
// pmsvr_host: host controller model making single-byte register accesses
`timescale 1ns/100ps
module pmsvr_host (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  // bus idle from time zero
  initial
  begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  // write one byte; chk reads the same place in the very next cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic chk,
    output logic [7:0] q);
    @(negedge clk);
    wr_en = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr_en = 1'b0;
    rd_en = chk;
    wdata = ~d;
    if (chk)
    begin
      @(negedge clk);
      rd_en = 1'b0;
    end
    q = rdata;
    addr = ~a;
  endtask
  // read strobe for one cycle; answer is taken one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] q, output logic v);
    @(negedge clk);
    rd_en = 1'b1;
    addr = a;
    @(negedge clk);
    q = rdata;
    v = rd_valid;
    rd_en = 1'b0;
    addr = ~a;
  endtask
endmodule

// *** testbench/pmsvr_regs_properties.sv ***
// pmsvr_regs_properties: port timing checks of the shutdown and voltage register slice
`timescale 1ns/100ps
module pmsvr_regs_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic sleep_request_n,
  input wire logic force_shutdown,
  input wire logic [6:0] converter_four_code,
  input wire logic [6:0] converter_five_code,
  input wire logic [6:0] converter_six_code,
  input wire logic ldo_two_in_sleep,
  input wire logic [2:0] power_good_hold
);
  // one clock domain, so one clocking and one disable for all
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  shutdown_fire_a: assert property (reg_wr_en && reg_addr == 8'h91 && reg_wdata[0]
    |-> ##2 force_shutdown) else $error("shutdown pulse missing");
  shutdown_cause_a: assert property (force_shutdown |-> $past(reg_wr_en, 2)
    && $past(reg_addr, 2) == 8'h91 && $past(reg_wdata[0], 2)) else $error("stray shutdown");
  shutdown_once_a: assert property (force_shutdown
    && !$past(reg_wr_en && reg_addr == 8'h91 && reg_wdata[0]) |=> !force_shutdown)
    else $error("shutdown pulse too long");
  read_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read not answered");
  read_idle_a: assert property (!reg_rd_en |=> !reg_rd_valid && reg_rdata == 8'h00)
    else $error("read data not idle");
  code_write_a: assert property (reg_wr_en && reg_addr == 8'h94
    |-> ##2 converter_four_code == $past(reg_wdata[6:0], 2)) else $error("code not taken");
  zero_good_a: assert property (power_good_hold == {converter_six_code == 7'h00,
    converter_five_code == 7'h00, converter_four_code == 7'h00}) else $error("hold wrong");
  sleep_enter_a: assert property (!sleep_request_n [*5] |-> ldo_two_in_sleep)
    else $error("sleep not entered");
  sleep_leave_a: assert property (sleep_request_n [*5] |-> !ldo_two_in_sleep)
    else $error("sleep not left");
endmodule
bind pmsvr_regs pmsvr_regs_properties chk_u (.clk, .rst_n, .reg_wr_en, .reg_rd_en,
  .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_valid, .sleep_request_n, .force_shutdown,
  .converter_four_code, .converter_five_code, .converter_six_code, .ldo_two_in_sleep,
  .power_good_hold);

// *** testbench/tb_top.sv ***
// tb_top: self-checking bench of the shutdown and voltage register slice
`timescale 1ns/100ps
module tb_top;
  logic clk, rst_n, wr_en, rd_en, rd_valid, pin_n, shut_pulse, in_slp;
  logic [7:0] addr, wdata, rdata, q;
  logic [6:0] c4, c5, c6;
  logic [3:0] ldo;
  logic [2:0] pg;
  int err_total = 0;
  int num_checks = 0;
  int sd_cnt = 0; // cycles seen with the shutdown output high
  pmsvr_host host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .rd_valid(rd_valid));
  pmsvr_regs dut_u (.clk(clk), .rst_n(rst_n), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
    .sleep_request_n(pin_n), .force_shutdown(shut_pulse), .converter_four_code(c4),
    .converter_five_code(c5), .converter_six_code(c6), .ldo_two_code(ldo),
    .ldo_two_in_sleep(in_slp), .power_good_hold(pg));
  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // count cycles with the shutdown output high; sampled mid-cycle, away from the launching edge
  always @(negedge clk)
  begin
    if (shut_pulse === 1'b1)
    begin
      sd_cnt++;
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // read and compare, answer must be flagged valid
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic v;
    host_u.rd(a, q, v);
    check({7'h00, v}, 8'h01);
    check(q, exp);
  endtask
  task automatic t_reset();
    rdc(8'h91, 8'h00);
    rdc(8'h94, 8'h2f);
    rdc(8'h96, 8'h4b);
    rdc(8'h98, 8'h3d);
    rdc(8'h9a, 8'haa);
    rdc(8'h92, 8'h00);
    check({1'b0, c4}, 8'h2f);
    check({1'b0, c5}, 8'h4b);
    check({1'b0, c6}, 8'h3d);
    check({4'h0, ldo}, 8'h0a);
    check({5'h00, pg}, 8'h00);
    $display("reset value test done");
  endtask
  task automatic t_shutdown();
    host_u.wr(8'h91, 8'hfe, 1'b1, q);
    check(q, 8'h00);
    host_u.wr(8'h91, 8'h01, 1'b1, q);
    check(q, 8'h01);
    repeat (3) @(negedge clk);
    check(sd_cnt[7:0], 8'h01);
    rdc(8'h91, 8'h00);
    host_u.wr(8'h91, 8'h00, 1'b0, q);
    repeat (3) @(negedge clk);
    check(sd_cnt[7:0], 8'h01);
    $display("shutdown test done");
  endtask
  task automatic t_codes();
    host_u.wr(8'h94, 8'hff, 1'b0, q);
    rdc(8'h94, 8'h7f);
    host_u.wr(8'h94, 8'h00, 1'b0, q);
    host_u.wr(8'h96, 8'h00, 1'b0, q);
    host_u.wr(8'h98, 8'h00, 1'b0, q);
    @(negedge clk);
    check({1'b0, c6}, 8'h00);
    check({1'b0, c4}, 8'h00);
    check({5'h00, pg}, 8'h07);
    host_u.wr(8'h96, 8'h55, 1'b0, q);
    @(negedge clk);
    check({1'b0, c5}, 8'h55);
    check({5'h00, pg}, 8'h05);
    $display("code test done");
  endtask
  // sleep pin held for five cycles, longer than sync plus output stage
  task automatic slp(input logic p, input logic [3:0] exp);
    pin_n = p;
    repeat (5) @(negedge clk);
    check({4'h0, ldo}, {4'h0, exp});
    check({7'h00, in_slp}, {7'h00, ~p});
  endtask
  task automatic t_sleep();
    host_u.wr(8'h9a, 8'h35, 1'b0, q);
    slp(1'b0, 4'h3);
    slp(1'b1, 4'h5);
    host_u.wr(8'h9a, 8'h55, 1'b0, q);
    slp(1'b0, 4'h5);
    slp(1'b1, 4'h5);
    $display("sleep test done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
    begin
      $display("No errors found");
    end
    else
    begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // main sequence after ten reset cycles
  initial
  begin
    rst_n = 1'b0;
    pin_n = 1'b1;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_shutdown();
    t_codes();
    t_sleep();
    conclude();
  end
  // watchdog, well past the under one hundred cycles the tests need
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule
